// ---- include/asuw_regs.svh ----
// Register indices, field positions, reset values and timing counts
`ifndef ASUW_REGS_SVH
`define ASUW_REGS_SVH

// Register indices; byte address is four times the index
`define ASUW_IDX_CTRL1 8'h2C
`define ASUW_IDX_CTRL2 8'h2D
`define ASUW_IDX_STATUS 8'h2E
`define ASUW_IDX_DATA 8'h2F

// serial_ctrl1_reg fields
`define ASUW_C1_RX9 7
`define ASUW_C1_TX9 6
`define ASUW_C1_MODE9 4
`define ASUW_C1_WAKE 3

// serial_ctrl2_reg fields
`define ASUW_C2_TXON 3
`define ASUW_C2_RXON 2
`define ASUW_C2_SLEEP 1
`define ASUW_C2_BRK 0

// serial_status_reg fields
`define ASUW_SR_TX_BUFFER_EMPTY 7
`define ASUW_SR_TC 6
`define ASUW_SR_RX_BUFFER_FULL 5
`define ASUW_SR_IDLE 4
`define ASUW_SR_OVR 3
`define ASUW_SR_NF 2
`define ASUW_SR_FE 1

// Reset values
`define ASUW_CTRL1_RST 8'h00
`define ASUW_CTRL2_RST 8'h00
`define ASUW_STATUS_RST 8'hC0

// Sample ticks per bit
`define ASUW_OVERSAMPLE 16

`endif

// ---- include/asuw_pkg.sv ----
// Types shared by the serial block
`default_nettype none
package asuw_pkg;

  typedef enum logic {ASUW_TX_IDLE, ASUW_TX_SEND} asuw_tx_st_t;
  typedef enum logic {ASUW_RX_IDLE, ASUW_RX_BUSY} asuw_rx_st_t;

  typedef struct packed {
    logic wreq;
    logic [7:0] rdata;
    logic rx9;
    logic tx9;
    logic mode9;
    logic wake;
    logic tx_on;
    logic rx_on;
    logic sleep;
    logic brk;
    logic tx_buffer_empty;
    logic tc;
    logic rx_buffer_full;
    logic idle;
    logic ovr;
    logic nf;
    logic fe;
    logic [4:0] rx_snap;
    logic [1:0] tx_snap;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    asuw_tx_st_t tx_st;
    logic [10:0] tx_sh;
    logic tx_fill;
    logic [3:0] tx_bits;
    logic [3:0] tx_tick;
    logic pre_pend;
    logic brk_pend;
    logic txd;
    asuw_rx_st_t rx_st;
    logic [3:0] rx_tick;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    logic smp0;
    logic smp1;
    logic noise;
    logic [7:0] idle_cnt;
    logic idle_arm;
  } asuw_state_t;

endpackage : asuw_pkg
`default_nettype wire

// ---- hdl/asuw_uart.sv ----
// Asynchronous serial transmitter and receiver with wakeup, Avalon-MM slave
//
// Operation
// [RL1] Line idles high; start bit is zero, stop bit is one.
// [RL2] Data bits go onto and come off the line LSB first.
// [RL3] Break is whole frames of zero; sent on request, seen as framing error.
// [RL4] Mode bit picks eight or nine data bits, one start, one stop.
// [RL5] Transmit shifter loads only from the transmit buffer.
// [RL6] Output pin follows the shifter while sending or transmitter is on.
// [RL7] Receive shifter moves each whole word into the receive buffer.
// [RL8] Three samples per bit; majority gives value, disagreement marks noise.
// [RL9] While sleeping no receiver flag can become set.
// [RL10] Software sets sleep; hardware clears it on wakeup; software may clear.
// [RL11] Idle-line wakeup clears sleep once a full idle frame is seen.
// [RL12] Address-mark wakeup clears sleep before the stop bit arrives.
// [RL13] Last data bit of a character marks an address when one.
// [RL14] Wake bit zero selects idle line, one selects address mark.
// [RL15] New character while buffer full sets overrun; new data dropped.
// [RL16] Overrun clears by status read with it set, then data read.
// [RL17] Noise flag raised with buffer full; cleared by status then data read.
// [RL18] Missing stop bit sets framing error together with buffer full.
// [RL19] Framing error plus overrun on one character reports overrun only.
// [RL20] Framing error blocks transfers; cleared by status then data read.
// [RL21] Data address reads receive buffer, writes transmit buffer.
// [RL22] Ninth received bit and ninth transmit bit live in control one.
// [RL23] Transmitter on rising queues one idle frame as preamble.
// [RL24] Buffer-empty flag cleared by status read then data write.
// [RL25] Each send-break write queues a break; breaks repeat while set.
// [RL26] Idle flag sets again only after the line was active.
// [RL27] Sixteen-times baud tick drives both receive sampling and bit timing.
`include "asuw_regs.svh"
`default_nettype none

module asuw_uart #(
  parameter int OVERSAMPLE = `ASUW_OVERSAMPLE
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic baud_tick,
  input wire logic rxd,
  output logic txd
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants

  // Counters are four bits; fewer than eight ticks leave no room to vote
  if (OVERSAMPLE < 8 || OVERSAMPLE > 16) begin : g_bad_osr
    $error("OVERSAMPLE must lie between 8 and 16");
  end

  localparam logic [3:0] SMP0 = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0] SMP1 = 4'(OVERSAMPLE / 2);
  localparam logic [3:0] SMP2 = 4'(OVERSAMPLE / 2 + 1);
  localparam logic [3:0] TLAST = 4'(OVERSAMPLE - 1);
  localparam logic [7:0] IDLE8 = 8'(10 * OVERSAMPLE);
  localparam logic [7:0] IDLE9 = 8'(11 * OVERSAMPLE);
  localparam logic [7:0] C1_RST = `ASUW_CTRL1_RST;
  localparam logic [7:0] C2_RST = `ASUW_CTRL2_RST;
  localparam logic [7:0] SR_RST = `ASUW_STATUS_RST;

  asuw_pkg::asuw_state_t s_r;
  asuw_pkg::asuw_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic req;
  logic take;
  logic wr_ok;
  logic hit_c1;
  logic hit_c2;
  logic hit_sr;
  logic hit_dr;
  logic [7:0] rd_mux;
  logic [7:0] wd;
  logic st_rd;
  logic dr_rd;

  assign req = avs_read | avs_write;
  assign take = req & ~s_r.wreq;
  assign wr_ok = take & avs_write & avs_byteenable[0];
  assign wd = avs_writedata[7:0];
  assign hit_c1 = avs_address[9:2] == `ASUW_IDX_CTRL1;
  assign hit_c2 = avs_address[9:2] == `ASUW_IDX_CTRL2;
  assign hit_sr = avs_address[9:2] == `ASUW_IDX_STATUS;
  assign hit_dr = avs_address[9:2] == `ASUW_IDX_DATA;
  assign st_rd = take & avs_read & hit_sr;
  assign dr_rd = take & avs_read & hit_dr;

  always_comb begin
    rd_mux = 8'h00;
    if (hit_c1) begin
      rd_mux[`ASUW_C1_RX9] = s_r.rx9;  // [RL22]
      rd_mux[`ASUW_C1_TX9] = s_r.tx9;
      rd_mux[`ASUW_C1_MODE9] = s_r.mode9;
      rd_mux[`ASUW_C1_WAKE] = s_r.wake;
    end else if (hit_c2) begin
      rd_mux[`ASUW_C2_TXON] = s_r.tx_on;
      rd_mux[`ASUW_C2_RXON] = s_r.rx_on;
      rd_mux[`ASUW_C2_SLEEP] = s_r.sleep;
      rd_mux[`ASUW_C2_BRK] = s_r.brk;
    end else if (hit_sr) begin
      rd_mux[`ASUW_SR_TX_BUFFER_EMPTY] = s_r.tx_buffer_empty;
      rd_mux[`ASUW_SR_TC] = s_r.tc;
      rd_mux[`ASUW_SR_RX_BUFFER_FULL] = s_r.rx_buffer_full;
      rd_mux[`ASUW_SR_IDLE] = s_r.idle;
      rd_mux[`ASUW_SR_OVR] = s_r.ovr;
      rd_mux[`ASUW_SR_NF] = s_r.nf;
      rd_mux[`ASUW_SR_FE] = s_r.fe;
    end else if (hit_dr) begin
      rd_mux = s_r.rx_buf;  // [RL21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [3:0] nbits;
  logic [3:0] tx_len;
  logic [7:0] idle_thr;
  logic vote;
  logic nz;

  assign nbits = s_r.mode9 ? 4'h9 : 4'h8;  // [RL4]
  assign tx_len = s_r.mode9 ? 4'hB : 4'hA;
  assign idle_thr = s_r.mode9 ? IDLE9 : IDLE8;
  assign vote = (s_r.smp0 & s_r.smp1) | (s_r.smp0 & rxd) | (s_r.smp1 & rxd);  // [RL8]
  assign nz = ~((s_r.smp0 == s_r.smp1) && (s_r.smp1 == rxd));

  always_comb begin
    s_nxt = s_r;

    // Bus handshake: one wait cycle, then accept
    // Read data loads in the wait cycle and stands at the accept edge
    s_nxt.wreq = ~(req & s_r.wreq);
    if (req & s_r.wreq) begin
      s_nxt.rdata = rd_mux;
    end

    //////////////////////////////////////////////////////////////////////////
    // Register writes

    if (wr_ok && hit_c1) begin
      s_nxt.tx9 = wd[`ASUW_C1_TX9];  // [RL22]
      s_nxt.mode9 = wd[`ASUW_C1_MODE9];
      s_nxt.wake = wd[`ASUW_C1_WAKE];  // [RL14]
    end
    if (wr_ok && hit_c2) begin
      s_nxt.tx_on = wd[`ASUW_C2_TXON];
      s_nxt.rx_on = wd[`ASUW_C2_RXON];
      s_nxt.sleep = wd[`ASUW_C2_SLEEP];  // [RL10]
      s_nxt.brk = wd[`ASUW_C2_BRK];
      if (wd[`ASUW_C2_TXON] && !s_r.tx_on) begin
        s_nxt.pre_pend = 1'b1;  // [RL23]
      end
      if (wd[`ASUW_C2_BRK]) begin
        s_nxt.brk_pend = 1'b1;  // [RL25]
      end
    end
    if (wr_ok && hit_dr) begin
      s_nxt.tx_buf = wd;  // [RL21]
      if (s_r.tx_snap[1]) begin
        s_nxt.tx_buffer_empty = 1'b0;  // [RL24]
      end
      if (s_r.tx_snap[0]) begin
        s_nxt.tc = 1'b0;
      end
      s_nxt.tx_snap = 2'h0;
    end

    // Snapshot of what software saw, so only flags it read get cleared
    if (st_rd) begin
      s_nxt.rx_snap = {s_r.rdata[`ASUW_SR_RX_BUFFER_FULL], s_r.rdata[`ASUW_SR_IDLE], s_r.rdata[`ASUW_SR_OVR],
                       s_r.rdata[`ASUW_SR_NF], s_r.rdata[`ASUW_SR_FE]};
      s_nxt.tx_snap = {s_r.rdata[`ASUW_SR_TX_BUFFER_EMPTY], s_r.rdata[`ASUW_SR_TC]};
    end
    if (dr_rd) begin
      if (s_r.rx_snap[4]) s_nxt.rx_buffer_full = 1'b0;
      if (s_r.rx_snap[3]) s_nxt.idle = 1'b0;
      if (s_r.rx_snap[2]) s_nxt.ovr = 1'b0;  // [RL16]
      if (s_r.rx_snap[1]) s_nxt.nf = 1'b0;  // [RL17]
      if (s_r.rx_snap[0]) s_nxt.fe = 1'b0;  // [RL20]
      s_nxt.rx_snap = 5'h00;
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmitter; hardware sets come after bus clears so they win

    unique case (s_r.tx_st)
      asuw_pkg::ASUW_TX_IDLE: begin
        s_nxt.tx_sh = 11'h7FF;
        if (s_r.tx_on) begin
          s_nxt.tx_tick = 4'h0;
          s_nxt.tx_bits = 4'h0;
          if (s_r.pre_pend) begin
            s_nxt.tx_sh = 11'h7FF;  // [RL23]
            s_nxt.tx_fill = 1'b1;
            s_nxt.pre_pend = 1'b0;
            s_nxt.tx_st = asuw_pkg::ASUW_TX_SEND;
          end else if (s_r.brk || s_r.brk_pend) begin
            s_nxt.tx_sh = 11'h000;  // [RL3] [RL25]
            s_nxt.tx_fill = 1'b0;
            s_nxt.brk_pend = 1'b0;
            s_nxt.tx_st = asuw_pkg::ASUW_TX_SEND;
          end else if (!s_r.tx_buffer_empty) begin
            // Stop, ninth, data, start; shifted out from bit 0
            if (s_r.mode9) begin
              s_nxt.tx_sh = {1'b1, s_r.tx9, s_r.tx_buf, 1'b0};  // [RL1] [RL2] [RL5] [RL22]
            end else begin
              s_nxt.tx_sh = {2'h3, s_r.tx_buf, 1'b0};  // [RL1] [RL2] [RL5]
            end
            s_nxt.tx_fill = 1'b1;
            s_nxt.tx_buffer_empty = 1'b1;
            s_nxt.tx_st = asuw_pkg::ASUW_TX_SEND;
          end
        end
      end
      asuw_pkg::ASUW_TX_SEND: begin
        if (baud_tick) begin  // [RL27]
          if (s_r.tx_tick == TLAST) begin
            s_nxt.tx_tick = 4'h0;
            s_nxt.tx_sh = {s_r.tx_fill, s_r.tx_sh[10:1]};
            if (s_r.tx_bits == tx_len - 4'h1) begin
              s_nxt.tx_bits = 4'h0;
              if (s_r.tx_fill || !s_r.brk) begin
                s_nxt.tx_sh = 11'h7FF;
              end else begin
                // Held break keeps the line low into the next break frame
                s_nxt.tx_sh = 11'h000;  // [RL3] [RL25]
              end
              s_nxt.tx_st = asuw_pkg::ASUW_TX_IDLE;
            end else begin
              s_nxt.tx_bits = s_r.tx_bits + 4'h1;
            end
          end else begin
            s_nxt.tx_tick = s_r.tx_tick + 4'h1;
          end
        end
      end
    endcase

    if (s_nxt.tx_st == asuw_pkg::ASUW_TX_IDLE && s_nxt.tx_buffer_empty && !s_nxt.pre_pend
        && !s_nxt.brk_pend && !s_nxt.brk) begin
      s_nxt.tc = 1'b1;
    end
    // Idle shifter holds ones, so an enabled idle line rests high; a disabled one is forced high
    if (s_nxt.tx_st == asuw_pkg::ASUW_TX_SEND || s_nxt.tx_on) begin
      s_nxt.txd = s_nxt.tx_sh[0];  // [RL6]
    end else begin
      s_nxt.txd = 1'b1;  // [RL1]
    end

    //////////////////////////////////////////////////////////////////////////
    // Receiver

    if (!s_r.rx_on) begin
      s_nxt.rx_st = asuw_pkg::ASUW_RX_IDLE;
      s_nxt.rx_tick = 4'h0;
      s_nxt.rx_bits = 4'h0;
      s_nxt.idle_cnt = 8'h00;
    end else if (baud_tick) begin  // [RL27]
      unique case (s_r.rx_st)
        asuw_pkg::ASUW_RX_IDLE: begin
          if (!rxd) begin
            s_nxt.rx_st = asuw_pkg::ASUW_RX_BUSY;
            s_nxt.rx_tick = 4'h1;
            s_nxt.rx_bits = 4'h0;
            s_nxt.noise = 1'b0;
            s_nxt.idle_cnt = 8'h00;
            s_nxt.idle_arm = 1'b1;  // [RL26]
          end else if (s_r.idle_cnt != idle_thr) begin
            // Counter stops at the threshold; the arm bit allows one report per quiet spell
            s_nxt.idle_cnt = s_r.idle_cnt + 8'h01;
            if (s_r.idle_cnt + 8'h01 == idle_thr && s_r.idle_arm) begin
              s_nxt.idle_arm = 1'b0;  // [RL26]
              if (s_r.sleep && !s_r.wake) begin
                s_nxt.sleep = 1'b0;  // [RL10] [RL11] [RL14]
              end else if (!s_r.sleep) begin
                s_nxt.idle = 1'b1;  // [RL9]
              end
            end
          end
        end
        asuw_pkg::ASUW_RX_BUSY: begin
          s_nxt.rx_tick = (s_r.rx_tick == TLAST) ? 4'h0 : s_r.rx_tick + 4'h1;
          if (s_r.rx_tick == TLAST) begin
            s_nxt.rx_bits = s_r.rx_bits + 4'h1;
          end
          if (s_r.rx_tick == SMP0) begin
            s_nxt.smp0 = rxd;
          end
          if (s_r.rx_tick == SMP1) begin
            s_nxt.smp1 = rxd;
          end
          if (s_r.rx_tick == SMP2) begin
            s_nxt.noise = s_r.noise | nz;  // [RL8] [RL17]
            if (s_r.rx_bits == 4'h0) begin
              // Start bit voted high: a glitch, not a frame
              if (vote) begin
                s_nxt.rx_st = asuw_pkg::ASUW_RX_IDLE;
              end
            end else if (s_r.rx_bits <= nbits) begin
              s_nxt.rx_sh = {vote, s_r.rx_sh[8:1]};  // [RL2]
              if (s_r.rx_bits == nbits && s_r.wake && s_r.sleep && vote) begin
                s_nxt.sleep = 1'b0;  // [RL12] [RL13] [RL14] [RL10]
              end
            end else begin
              s_nxt.rx_st = asuw_pkg::ASUW_RX_IDLE;
              if (!s_nxt.sleep) begin  // [RL9]
                // Overrun is tested first so a character with both errors reports overrun only
                if (s_r.rx_buffer_full) begin
                  s_nxt.ovr = 1'b1;  // [RL15] [RL19]
                end else if (!s_r.fe) begin  // [RL20]
                  s_nxt.rx_buf = s_r.mode9 ? s_r.rx_sh[7:0] : s_r.rx_sh[8:1];  // [RL7]
                  if (s_r.mode9) begin
                    s_nxt.rx9 = s_r.rx_sh[8];  // [RL22]
                  end
                  s_nxt.rx_buffer_full = 1'b1;
                  s_nxt.fe = ~vote;  // [RL18] [RL1] [RL3]
                  s_nxt.nf = s_r.noise | nz;  // [RL17]
                end
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.wreq <= 1'b1;
      s_r.rx9 <= C1_RST[`ASUW_C1_RX9];
      s_r.tx9 <= C1_RST[`ASUW_C1_TX9];
      s_r.mode9 <= C1_RST[`ASUW_C1_MODE9];
      s_r.wake <= C1_RST[`ASUW_C1_WAKE];
      s_r.tx_on <= C2_RST[`ASUW_C2_TXON];
      s_r.rx_on <= C2_RST[`ASUW_C2_RXON];
      s_r.sleep <= C2_RST[`ASUW_C2_SLEEP];
      s_r.brk <= C2_RST[`ASUW_C2_BRK];
      s_r.tx_buffer_empty <= SR_RST[`ASUW_SR_TX_BUFFER_EMPTY];
      s_r.tc <= SR_RST[`ASUW_SR_TC];
      s_r.rx_buffer_full <= SR_RST[`ASUW_SR_RX_BUFFER_FULL];
      s_r.idle <= SR_RST[`ASUW_SR_IDLE];
      s_r.ovr <= SR_RST[`ASUW_SR_OVR];
      s_r.nf <= SR_RST[`ASUW_SR_NF];
      s_r.fe <= SR_RST[`ASUW_SR_FE];
      s_r.tx_st <= asuw_pkg::ASUW_TX_IDLE;
      s_r.rx_st <= asuw_pkg::ASUW_RX_IDLE;
      s_r.tx_sh <= 11'h7FF;
      s_r.txd <= 1'b1;
      s_r.idle_arm <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = {24'h000000, s_r.rdata};
  assign avs_waitrequest = s_r.wreq;
  assign txd = s_r.txd;

endmodule : asuw_uart
`default_nettype wire

// ---- verif/asuw_uart_asserts.sv ----
// Port-level checks of the serial block, bound to its top module
`include "asuw_regs.svh"
`default_nettype none
module asuw_uart_asserts #(
  parameter int OVERSAMPLE = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic txd
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property ((avs_read || avs_write) && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low with no request");
  a_rd_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_rdata_hold: assert property (avs_read && !avs_waitrequest |=> $stable(avs_readdata))
    else $error("read data changed right after accept");
  a_ctrl2_zero: assert property (avs_read && !avs_waitrequest && avs_address[9:2] == `ASUW_IDX_CTRL2
    |-> avs_readdata[7:4] == 4'h0)
    else $error("unused control bits read nonzero");
  a_status_bit0: assert property (avs_read && !avs_waitrequest && avs_address[9:2] == `ASUW_IDX_STATUS
    |-> !avs_readdata[0])
    else $error("status bit zero read as one");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[9:4] != 6'h0B
    |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_start_low: assert property ($fell(txd) |=> (!txd) [*8])
    else $error("start bit too short");
endmodule : asuw_uart_asserts
////////////////////////////////////////////////////////////////
bind asuw_uart asuw_uart_asserts #(.OVERSAMPLE(OVERSAMPLE)) i_asuw_uart_asserts (
  .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txd(txd));
`default_nettype wire

// ---- verif/asuw_peer.sv ----
// Serial peer: drives the receive line and captures the transmit line
`default_nettype none
module asuw_peer (
  input wire logic sys_clk,
  input wire logic baud_tick,
  input wire logic txd,
  output var logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////////
  task automatic ticks(input int n);
    repeat (n) begin
      do @(posedge sys_clk); while (baud_tick !== 1'b1);
    end
  endtask : ticks
  // Back-to-back frames leave only one tick of idle line between them
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input logic glitch = 1'b0);
    ticks(1);
    rxd <= 1'b0;
    ticks(16);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      if (glitch && i == 0) begin
        // One flipped sample mid-bit: vote still right, noise reported
        ticks(8);
        rxd <= ~d[i];
        ticks(1);
        rxd <= d[i];
        ticks(7);
      end else begin
        ticks(16);
      end
    end
    rxd <= stop;
    ticks(16);
    rxd <= 1'b1;
  endtask : send
  // Samples mid-bit, so finding the start edge up to half a bit late is tolerated
  task automatic catch(output logic [7:0] d, output logic stop, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (txd !== 1'b0);
    ticks(8);
    for (int i = 0; i < 8; i++) begin
      ticks(16);
      d[i] = txd;
    end
    ticks(16);
    stop = txd;
  endtask : catch
endmodule : asuw_peer
`default_nettype wire

// ---- verif/tb_asuw_uart.sv ----
// Register-level tests of the serial block against a serial peer
`include "asuw_regs.svh"
`default_nettype none
module tb_asuw_uart;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic baud_tick = 1'b0;
  logic rxd;
  logic txd;
  int n_mismatch = 0;
  int checked = 0;
  logic [7:0] d;
  logic s;
  int n;
  asuw_uart #(.OVERSAMPLE(16)) i_asuw_uart (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .baud_tick(baud_tick), .rxd(rxd), .txd(txd));
  asuw_peer i_asuw_peer (.sys_clk(sys_clk), .baud_tick(baud_tick), .txd(txd), .rxd(rxd));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  // Tick every other cycle keeps frames short
  always @(posedge sys_clk) begin
    baud_tick <= ~baud_tick;
  end
  ////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, wd};
    avs_byteenable <= 4'hF;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] x;
    bus(1'b1, idx, v, x);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    chk(v & m, exp);
  endtask : rdc
  task automatic wait_flag(input logic [7:0] m);
    logic [7:0] v;
    v = 8'h00;
    while ((v & m) === 8'h00) begin
      bus(1'b0, `ASUW_IDX_STATUS, 8'h00, v);
    end
  endtask : wait_flag
  task automatic conclude();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(`ASUW_IDX_STATUS, 8'hFF, 8'hC0);
    rdc(`ASUW_IDX_CTRL1, 8'hFF, 8'h00);
    rdc(`ASUW_IDX_CTRL2, 8'hFF, 8'h00);
    rdc(8'h10, 8'hFF, 8'h00);
    wr(`ASUW_IDX_CTRL2, 8'h0C);
    rdc(`ASUW_IDX_STATUS, 8'h80, 8'h80);
    wr(`ASUW_IDX_DATA, 8'hA5);
    rdc(`ASUW_IDX_STATUS, 8'h80, 8'h00);
    i_asuw_peer.catch(d, s, n);
    chk(d, 8'hA5);
    chk({7'h00, s}, 8'h01);
    chk({7'h00, n > 250}, 8'h01);
    wr(`ASUW_IDX_CTRL2, 8'h0D);
    i_asuw_peer.catch(d, s, n);
    wr(`ASUW_IDX_CTRL2, 8'h0C);
    chk({7'h00, {d, s} == 9'h000}, 8'h01);
    i_asuw_peer.send(9'h03C, 8, 1'b1);
    wait_flag(8'h20);
    rdc(`ASUW_IDX_STATUS, 8'h2E, 8'h20);
    rdc(`ASUW_IDX_DATA, 8'hFF, 8'h3C);
    i_asuw_peer.send(9'h011, 8, 1'b1);
    i_asuw_peer.send(9'h022, 8, 1'b1);
    wait_flag(8'h08);
    rdc(`ASUW_IDX_STATUS, 8'h2E, 8'h28);
    rdc(`ASUW_IDX_DATA, 8'hFF, 8'h11);
    rdc(`ASUW_IDX_STATUS, 8'h2E, 8'h00);
    i_asuw_peer.send(9'h033, 8, 1'b1);
    i_asuw_peer.send(9'h044, 8, 1'b0);
    wait_flag(8'h08);
    rdc(`ASUW_IDX_STATUS, 8'h2E, 8'h28);
    rdc(`ASUW_IDX_DATA, 8'hFF, 8'h33);
    i_asuw_peer.send(9'h055, 8, 1'b0);
    wait_flag(8'h20);
    rdc(`ASUW_IDX_STATUS, 8'h2E, 8'h22);
    rdc(`ASUW_IDX_DATA, 8'hFF, 8'h55);
    i_asuw_peer.send(9'h066, 8, 1'b1, 1'b1);
    wait_flag(8'h20);
    rdc(`ASUW_IDX_STATUS, 8'h2E, 8'h24);
    rdc(`ASUW_IDX_DATA, 8'hFF, 8'h66);
    // Address-mark wakeup: first char ignored, marked char received
    wr(`ASUW_IDX_CTRL1, 8'h08);
    wr(`ASUW_IDX_CTRL2, 8'h0E);
    i_asuw_peer.send(9'h012, 8, 1'b1);
    rdc(`ASUW_IDX_STATUS, 8'h2E, 8'h00);
    i_asuw_peer.send(9'h085, 8, 1'b1);
    wait_flag(8'h20);
    rdc(`ASUW_IDX_CTRL2, 8'hFF, 8'h0C);
    rdc(`ASUW_IDX_DATA, 8'hFF, 8'h85);
    wr(`ASUW_IDX_CTRL1, 8'h10);
    i_asuw_peer.send(9'h1A5, 9, 1'b1);
    wait_flag(8'h20);
    rdc(`ASUW_IDX_DATA, 8'hFF, 8'hA5);
    rdc(`ASUW_IDX_CTRL1, 8'hD0, 8'h90);
    // Idle-line wakeup needs a full quiet frame of ticks
    wr(`ASUW_IDX_CTRL2, 8'h0E);
    rdc(`ASUW_IDX_CTRL2, 8'hFF, 8'h0E);
    i_asuw_peer.ticks(200);
    rdc(`ASUW_IDX_CTRL2, 8'hFF, 8'h0C);
    rdc(`ASUW_IDX_STATUS, 8'h10, 8'h00);
    conclude();
  end
endmodule : tb_asuw_uart
`default_nettype wire
